// *** core/tco_pkg.sv ***
// shared constants, field layouts and carrier types of the transmit checksum offload block
package tco_pkg;

  // ----------------------------------------------------------------
  // packet buffer geometry
  // ----------------------------------------------------------------
  localparam int BUF_DEPTH = 2048; // bytes held per packet, covers long frames
  localparam int PTR_W = 12; // pointer width, one above the index width so a full buffer is countable
  localparam logic [PTR_W-1:0] BUF_FULL = 12'h800; // pointer value of a full buffer

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTX = 8'h00; // context: header lengths, layer-4 type, ipv4 flag
  localparam logic [7:0] OFF_CLASS = 8'h04; // packet class: extension, fragment, protocol, tunnel
  localparam logic [7:0] OFF_STATUS = 8'h08; // state of the block and of the last packet
  localparam logic [7:0] OFF_COUNT = 8'h0C; // packets sent

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTX_L2_LSB = 0; // header_len_l2, 7 bits
  localparam int CTX_L3_LSB = 8; // header_len_l3, 9 bits
  localparam int CTX_L4T_LSB = 18; // l4_type_code, 2 bits
  localparam int CTX_IPV4_BIT = 20; // packet is ipv4
  localparam int CTX_HEADER_LEN_L4_LSB = 24; // header_len_l4, 8 bits
  localparam int CLS_EXT_BAD_BIT = 0; // ipv6 routing len > 0, fragment or home extension present
  localparam int CLS_FRAG_BIT = 1; // packet is an ipv4 fragment
  localparam int CLS_PROTO_OTHER_BIT = 2; // ip protocol field names another protocol
  localparam int CLS_TUN_LSB = 3; // tunnel kind, 2 bits
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_IP_DONE_BIT = 1;
  localparam int STS_L4_DONE_BIT = 2;
  localparam int STS_SEG_REFUSED_BIT = 3;
  localparam int STS_CFG_ERR_BIT = 4;
  localparam int STS_CSUM_LSB = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTX_RST = 32'h0000_0000;
  localparam logic [31:0] CLASS_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings and fixed offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] L4T_UDP = 2'h0;
  localparam logic [1:0] L4T_TCP = 2'h1;
  localparam logic [1:0] L4T_SCTP = 2'h2;
  localparam logic [1:0] TUN_NONE = 2'h0;
  localparam logic [1:0] TUN_IPV4 = 2'h1;
  localparam logic [1:0] TUN_IPV6 = 2'h2;
  localparam logic [9:0] TCP_FIELD_OFF = 10'h010; // 16
  localparam logic [9:0] UDP_FIELD_OFF = 10'h006; // 6
  localparam logic [9:0] SCTP_FIELD_OFF = 10'h008; // 8
  localparam logic [9:0] IP_FIELD_OFF = 10'h00A; // 10
  localparam logic [9:0] MIN_START_UDP = 10'h020; // 32
  localparam logic [9:0] MIN_START_TCP = 10'h02A; // 42
  localparam logic [9:0] MIN_START_SCTP = 10'h01A; // 26
  localparam logic [6:0] L2_MIN = 7'h0C; // 12; the top of 127 is the field's own limit
  localparam logic [31:0] CRC_POLY = 32'h82F6_3B78; // crc32c, reflected
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data; // packet byte
    logic last; // final byte of the packet
  } tco_byte_t;

  typedef struct packed {
    logic ip_csum_insert_enable;
    logic l4_csum_insert_enable;
    logic frame_crc_append_enable;
    logic seg_request; // segmentation asked for; never granted here
  } tco_opts_t;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_FINISH,
    ST_SEND
  } tco_state_t;

endpackage

// *** core/tco_tx_csum_offload.sv ***
// transmit checksum and sctp crc insertion with an ahb-lite register slave
`timescale 1ns/1ps

module tco_tx_csum_offload import tco_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire tco_byte_t in_byte,
  input wire tco_opts_t in_opts,
  output logic in_ready,
  output logic out_valid,
  output tco_byte_t out_byte,
  output logic out_frame_crc_append,
  input wire logic out_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] ctx_reg; // context fields
  logic [31:0] class_reg; // packet class fields
  logic [31:0] pkt_count; // packets sent
  logic ahb_wr_pend; // write data phase pending
  logic [7:0] ahb_wr_addr; // captured write address
  logic ahb_go; // address phase taken this edge
  logic [31:0] rd_mux; // register read value
  tco_state_t state;
  logic [7:0] buf_mem [0:BUF_DEPTH-1]; // packet store, patched on the way out
  logic [PTR_W-1:0] wr_ptr; // bytes stored
  logic [PTR_W-1:0] rd_ptr; // next byte to send
  logic accept; // input handshake
  logic send_step; // output slot free
  logic send_done; // packet fully drained
  logic [6:0] cur_l2;
  logic [8:0] cur_l3;
  logic [1:0] cur_l4t;
  logic [9:0] cur_start; // first byte of layer-4 header
  logic [9:0] cur_min;
  logic [9:0] cur_fld_off;
  logic cfg_ok; // lengths are usable
  logic l4_cap; // packet type allows layer-4 insertion
  logic ip_cap; // packet type allows ip insertion
  logic want_l4;
  logic want_ip;
  logic [PTR_W-1:0] pk_l2; // latched per packet
  logic [PTR_W-1:0] pk_start;
  logic [PTR_W-1:0] pk_l4_fld;
  logic [PTR_W-1:0] pk_ip_fld;
  logic [1:0] pk_l4t;
  logic pk_do_l4;
  logic pk_do_ip;
  logic pk_crc_append;
  logic [31:0] sum_l4; // running 16-bit ones-complement sum, unfolded
  logic [31:0] sum_ip;
  logic [31:0] crc_run; // running crc32c
  logic [15:0] res_l4; // final layer-4 checksum
  logic [15:0] res_ip; // final ip header checksum
  logic [31:0] res_crc; // final sctp crc
  logic sts_ip_done;
  logic sts_l4_done;
  logic sts_seg_refused;
  logic sts_cfg_err;
  logic [PTR_W-1:0] idx; // index of the byte being stored
  logic [PTR_W-1:0] rel_l4;
  logic [PTR_W-1:0] rel_ip;
  logic [7:0] patched; // outgoing byte after field substitution

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // one byte of reflected crc32c
  function automatic logic [31:0] crc_byte(input logic [31:0] c_in, input logic [7:0] d);
    logic [31:0] c;
    c = c_in ^ {24'h00_0000, d};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // fold the wide sum to 16 bits and complement it
  function automatic logic [15:0] fold_cpl(input logic [31:0] s);
    logic [16:0] f1;
    logic [16:0] f2;
    f1 = {1'b0, s[15:0]} + {1'b0, s[31:16]};
    f2 = {1'b0, f1[15:0]} + {16'h0000, f1[16]};
    return ~(f2[15:0] + {15'h0000, f2[16]});
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states; every response is okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_go = hsel && htrans[1] && hready;

  // read mux; unmapped or unaligned addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFF_CTX: rd_mux = ctx_reg;
      OFF_CLASS: rd_mux = class_reg;
      OFF_STATUS: begin
        rd_mux[STS_BUSY_BIT] = (state != ST_LOAD) || (wr_ptr != 12'h000);
        rd_mux[STS_IP_DONE_BIT] = sts_ip_done;
        rd_mux[STS_L4_DONE_BIT] = sts_l4_done;
        rd_mux[STS_SEG_REFUSED_BIT] = sts_seg_refused;
        rd_mux[STS_CFG_ERR_BIT] = sts_cfg_err;
        rd_mux[STS_CSUM_LSB +: 16] = (pk_l4t == L4T_SCTP) ? res_crc[15:0] : res_l4;
      end
      OFF_COUNT: rd_mux = pkt_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture; read data is registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_pend <= 1'b0;
      ahb_wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      ahb_wr_pend <= ahb_go && hwrite;
      if (ahb_go) begin
        ahb_wr_addr <= haddr[7:0];
        hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // context and class registers; a write mid-packet only affects the next packet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctx_reg <= CTX_RST;
      class_reg <= CLASS_RST;
    end else if (ahb_wr_pend) begin
      if (ahb_wr_addr == OFF_CTX) begin
        ctx_reg <= hwdata;
      end
      if (ahb_wr_addr == OFF_CLASS) begin
        class_reg <= hwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-packet eligibility from context and class
  // ----------------------------------------------------------------
  always_comb begin
    cur_l2 = ctx_reg[CTX_L2_LSB +: 7];
    cur_l3 = ctx_reg[CTX_L3_LSB +: 9];
    cur_l4t = ctx_reg[CTX_L4T_LSB +: 2];
    cur_start = {3'h0, cur_l2} + {1'b0, cur_l3};
    case (cur_l4t)
      L4T_TCP: begin
        cur_min = MIN_START_TCP;
        cur_fld_off = TCP_FIELD_OFF;
      end
      L4T_UDP: begin
        cur_min = MIN_START_UDP;
        cur_fld_off = UDP_FIELD_OFF;
      end
      L4T_SCTP: begin
        cur_min = MIN_START_SCTP;
        cur_fld_off = SCTP_FIELD_OFF;
      end
      default: begin
        cur_min = 10'h3FF; // reserved type: never eligible
        cur_fld_off = 10'h000;
      end
    endcase
    // a header offset below the minimum is refused rather than patched blindly
    cfg_ok = (cur_l2 >= L2_MIN) && (cur_start >= cur_min);
    // extension headers, fragments and foreign protocols block layer-4 only
    l4_cap = cfg_ok && !class_reg[CLS_EXT_BAD_BIT] && !class_reg[CLS_FRAG_BIT]
             && !class_reg[CLS_PROTO_OTHER_BIT];
    // ipv6 never gets an ip sum, neither does anything in an ipv6 tunnel
    ip_cap = ctx_reg[CTX_IPV4_BIT] && (cur_l2 >= L2_MIN)
             && (class_reg[CLS_TUN_LSB +: 2] != TUN_IPV6);
    want_l4 = in_opts.l4_csum_insert_enable && l4_cap;
    // inside an ipv4 tunnel the layer-4 sum wins when both are asked for
    want_ip = in_opts.ip_csum_insert_enable && ip_cap
              && !((class_reg[CLS_TUN_LSB +: 2] == TUN_IPV4) && want_l4);
  end

  // ----------------------------------------------------------------
  // packet state machine
  // ----------------------------------------------------------------
  assign accept = in_valid && in_ready;
  assign in_ready = (state == ST_LOAD);
  assign send_step = !out_valid || out_ready;
  assign send_done = (state == ST_SEND) && (rd_ptr == wr_ptr) && send_step;

  // load until the last byte, settle the sums, then drain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: begin
          if (accept && in_byte.last) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: state <= ST_SEND;
        ST_SEND: begin
          if (send_done) begin
            state <= ST_LOAD;
          end
        end
        default: state <= ST_LOAD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // packet store
  // ----------------------------------------------------------------
  // bytes beyond the buffer are dropped; the frame is then sent truncated
  always_ff @(posedge hclk) begin
    if (accept && (wr_ptr != BUF_FULL)) begin
      buf_mem[wr_ptr[10:0]] <= in_byte.data;
    end
  end

  // write pointer doubles as the packet length while sending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 12'h000;
    end else if (send_done) begin
      wr_ptr <= 12'h000;
    end else if (accept && (wr_ptr != BUF_FULL)) begin
      wr_ptr <= wr_ptr + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // per-packet context capture on the first byte
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pk_l2 <= 12'h000;
      pk_start <= 12'h000;
      pk_l4_fld <= 12'h000;
      pk_ip_fld <= 12'h000;
      pk_l4t <= L4T_UDP;
      pk_do_l4 <= 1'b0;
      pk_do_ip <= 1'b0;
      pk_crc_append <= 1'b0;
    end else if (accept && (wr_ptr == 12'h000)) begin
      pk_l2 <= {5'h00, cur_l2};
      pk_start <= {2'h0, cur_start};
      pk_l4_fld <= {2'h0, cur_start} + {2'h0, cur_fld_off};
      pk_ip_fld <= {5'h00, cur_l2} + {2'h0, IP_FIELD_OFF};
      pk_l4t <= cur_l4t;
      pk_do_l4 <= want_l4;
      pk_do_ip <= want_ip;
      pk_crc_append <= in_opts.frame_crc_append_enable; // passed on to the mac path
    end
  end

  // ----------------------------------------------------------------
  // running sums while storing
  // ----------------------------------------------------------------
  // byte 0 always lies before both ranges (l2 >= 12) and is never summed:
  // the context is only latched on it, so the range pointers still hold the old packet's
  assign idx = wr_ptr;
  assign rel_l4 = idx - pk_start;
  assign rel_ip = idx - pk_l2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_l4 <= 32'h0000_0000;
      sum_ip <= 32'h0000_0000;
      crc_run <= CRC_INIT;
    end else if (state == ST_FINISH) begin
      sum_l4 <= 32'h0000_0000;
      sum_ip <= 32'h0000_0000;
      crc_run <= CRC_INIT;
    end else if (accept && (wr_ptr != BUF_FULL) && (idx != 12'h000)) begin
      // layer-4 range runs to the final stored byte; the field holds the pseudo-header sum
      if (idx >= pk_start) begin
        sum_l4 <= sum_l4 + (rel_l4[0] ? {24'h00_0000, in_byte.data} : {16'h0000, in_byte.data, 8'h00});
        crc_run <= crc_byte(crc_run, in_byte.data);
      end
      // ip header range, its own checksum field counted as zero
      if ((idx >= pk_l2) && (idx < pk_start) && (idx != pk_ip_fld) && (idx != pk_ip_fld + 12'h001)) begin
        sum_ip <= sum_ip + (rel_ip[0] ? {24'h00_0000, in_byte.data} : {16'h0000, in_byte.data, 8'h00});
      end
    end
  end

  // ----------------------------------------------------------------
  // final results and status
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_l4 <= 16'h0000;
      res_ip <= 16'h0000;
      res_crc <= 32'h0000_0000;
    end else if (state == ST_FINISH) begin
      // a udp result of zero means no checksum, so it goes out as all ones
      if ((pk_l4t == L4T_UDP) && (fold_cpl(sum_l4) == 16'h0000)) begin
        res_l4 <= 16'hFFFF;
      end else begin
        res_l4 <= fold_cpl(sum_l4);
      end
      res_ip <= fold_cpl(sum_ip);
      res_crc <= ~crc_run;
    end
  end

  // last-packet flags; seg_refused is sticky, write one to clear, a new refusal wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_ip_done <= 1'b0;
      sts_l4_done <= 1'b0;
      sts_seg_refused <= 1'b0;
      sts_cfg_err <= 1'b0;
    end else begin
      if (accept && (wr_ptr == 12'h000)) begin
        sts_ip_done <= want_ip;
        sts_l4_done <= want_l4;
        sts_cfg_err <= in_opts.l4_csum_insert_enable && !cfg_ok;
      end
      // segmentation is never carried out; for sctp or blocked types it is also unlawful
      if (accept && (wr_ptr == 12'h000) && in_opts.seg_request) begin
        sts_seg_refused <= 1'b1;
      end else if (ahb_wr_pend && (ahb_wr_addr == OFF_STATUS) && hwdata[STS_SEG_REFUSED_BIT]) begin
        sts_seg_refused <= 1'b0;
      end
    end
  end

  // packet counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_count <= 32'h0000_0000;
    end else if (send_done) begin
      pkt_count <= pkt_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // output path with field substitution
  // ----------------------------------------------------------------
  always_comb begin
    patched = buf_mem[rd_ptr[10:0]];
    if (pk_do_l4) begin
      if (pk_l4t == L4T_SCTP) begin
        // crc goes out least significant byte first
        if (rd_ptr == pk_l4_fld) patched = res_crc[7:0];
        if (rd_ptr == pk_l4_fld + 12'h001) patched = res_crc[15:8];
        if (rd_ptr == pk_l4_fld + 12'h002) patched = res_crc[23:16];
        if (rd_ptr == pk_l4_fld + 12'h003) patched = res_crc[31:24];
      end else begin
        if (rd_ptr == pk_l4_fld) patched = res_l4[15:8];
        if (rd_ptr == pk_l4_fld + 12'h001) patched = res_l4[7:0];
      end
    end
    if (pk_do_ip) begin
      if (rd_ptr == pk_ip_fld) patched = res_ip[15:8];
      if (rd_ptr == pk_ip_fld + 12'h001) patched = res_ip[7:0];
    end
  end

  // one-byte output register, refilled whenever the slot frees
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_byte <= '0;
      out_frame_crc_append <= 1'b0;
      rd_ptr <= 12'h000;
    end else if (state != ST_SEND) begin
      out_valid <= 1'b0;
      rd_ptr <= 12'h000;
    end else if (send_step) begin
      if (rd_ptr != wr_ptr) begin
        out_valid <= 1'b1;
        out_byte.data <= patched;
        out_byte.last <= (rd_ptr + 12'h001) == wr_ptr;
        out_frame_crc_append <= pk_crc_append;
        rd_ptr <= rd_ptr + 12'h001;
      end else begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // tco_tx_csum_offload

// *** verif/tco_host_model.sv ***
// host driver side: hands one prepared packet buffer to the block a byte per handshake
`timescale 1ns/1ps
module tco_host_model import tco_pkg::*; (
  input wire logic hclk,
  input wire logic gap,
  input wire logic in_ready,
  output logic in_valid,
  output tco_byte_t in_byte,
  output tco_opts_t in_opts
);
  logic [7:0] pkt [0:255]; // packet buffer, filled by the bench
  initial begin
    in_valid = 1'b0;
    in_byte = '0;
    in_opts = '0;
  end
  // ----------------------------------------------------------------
  // byte source; buffers keep headers short of the length pseudo sum in field
  // sctp payload in whole words and a zeroed crc field crc append always on
  // ----------------------------------------------------------------
  task automatic send(input int n, input tco_opts_t o);
    for (int i = 0; i < n; i++) begin
      while (gap) begin
        in_valid <= 1'b0;
        in_byte.data <= ~in_byte.data; // idle data keeps moving so stale bytes never match
        @(posedge hclk);
      end
      in_valid <= 1'b1;
      in_opts <= o;
      in_byte <= '{data: pkt[i], last: i == n - 1};
      do @(posedge hclk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
  endtask
endmodule // tco_host_model

// *** verif/tco_tx_csum_offload_sva.sv ***
// concurrent checks on the bus answer and the packet stream ports of the offload block
`timescale 1ns/1ps
module tco_tx_csum_offload_sva import tco_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic in_valid,
  input wire tco_byte_t in_byte,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire tco_byte_t out_byte,
  input wire logic out_frame_crc_append,
  input wire logic out_ready
);
  // ----------------------------------------------------------------
  // one clock domain, reset quiets every check
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // final byte of a packet handed in, and handed out
  sequence s_last_in; in_valid && in_ready && in_byte.last; endsequence
  sequence s_last_out; out_valid && out_ready && out_byte.last; endsequence
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("slave not ready or not okay");
  property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_byte); endproperty
  a_out_hold: assert property (p_out_hold) else $error("output byte changed before taken");
  property p_load_stop; s_last_in |=> !in_ready; endproperty
  a_load_stop: assert property (p_load_stop) else $error("input still open after final byte");
  property p_first_out; s_last_in |-> ##[1:4] out_valid; endproperty
  a_first_out: assert property (p_first_out) else $error("packet not sent after final byte");
  // the buffer is single: no loading while a packet drains
  property p_no_overlap; out_valid |-> !in_ready; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("input open while sending");
  property p_reload; s_last_out |-> ##[1:3] in_ready; endproperty
  a_reload: assert property (p_reload) else $error("input not reopened after packet");
  property p_one_frame; s_last_out |=> !out_valid; endproperty
  a_one_frame: assert property (p_one_frame) else $error("extra frame after packet end");
  property p_fcs_keep; out_valid && $past(out_valid) |-> $stable(out_frame_crc_append); endproperty
  a_fcs_keep: assert property (p_fcs_keep) else $error("crc append flag moved in packet");
endmodule // tco_tx_csum_offload_sva

bind tco_tx_csum_offload tco_tx_csum_offload_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp, .in_valid,
  .in_byte, .in_ready, .out_valid, .out_byte, .out_frame_crc_append, .out_ready);

// *** verif/tco_tx_csum_offload_tb_top.sv ***
// self-checking bench: packets of every layer-4 type and class through the offload block
`timescale 1ns/1ps
module tco_tx_csum_offload_tb_top import tco_pkg::*; ();
  logic hclk, hresetn, hsel, hwrite, in_valid, in_ready, out_valid, hreadyout, hresp;
  logic out_frame_crc_append, out_ready = 1'b0, gap = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] rs = 32'h48FC3A4A; // lfsr state for sink stalls and source gaps
  logic [1:0] htrans;
  tco_byte_t in_byte, out_byte;
  tco_opts_t in_opts;
  tco_byte_t exp_q [$]; // expected output bytes, oldest first
  logic [7:0] p [0:255]; // bench copy of the packet
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // case table: type, class flags, l2 length (l2+l3 always 42); ipv4 unless the extension flag is set
  logic [1:0] typ [8] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2};
  logic [4:0] cls [8] = '{5'h00, 5'h08, 5'h00, 5'h02, 5'h04, 5'h00, 5'h01, 5'h10};
  int l2 [8] = '{14, 12, 14, 14, 14, 11, 14, 14};

  tco_tx_csum_offload DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hreadyout, .hresp, .hrdata, .in_valid, .in_byte, .in_opts, .in_ready, .out_valid, .out_byte,
    .out_frame_crc_append, .out_ready);
  tco_host_model u_host (.hclk, .gap, .in_ready, .in_valid, .in_byte, .in_opts);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one single ahb-lite transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // ones-complement sum, pairs big endian from byte s up to n, odd tail padded low
  function automatic logic [15:0] l4sum(input int s, input int n);
    logic [31:0] a;
    a = 32'h0;
    for (int i = s; i < n; i += 2) a += {16'h0, p[i], (i + 1 < n) ? p[i + 1] : 8'h00};
    a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
    a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
    return ~a[15:0];
  endfunction
  function automatic logic [31:0] crc(input int s, input int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = s; i < n; i++) begin
      c ^= {24'h0, p[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  // ----------------------------------------------------------------
  // clock, random sink stalls, source gaps, hang guard
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    rs <= lfsr(rs);
    out_ready <= rs[3] | rs[7]; // sink stalls about a quarter of cycles
    gap <= rs[5] & rs[9];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // watcher: every byte taken is matched against the oldest note
  always @(posedge hclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({23'h0, out_byte}, {23'h0, exp_q.pop_front()});
      check(32'(out_frame_crc_append), 32'h1);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, rd, c;
    logic [1:0] t;
    logic [15:0] ic;
    logic el, v4, ipe;
    int n, s;
    {hresetn, hsel, hwrite, htrans} = 5'h00;
    {haddr, hwdata} = 64'h0;
    r = rs;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, OFF_CTX, 32'h0, rd);
    check(rd, CTX_RST);
    ahb(1'b0, OFF_CLASS, 32'h0, rd);
    check(rd, CLASS_RST);
    for (int k = 0; k < 8; k++) begin
      t = typ[k];
      s = 42;
      v4 = !cls[k][0];
      ahb(1'b1, OFF_CTX, 32'h1400_0000 | (v4 ? 32'h0010_0000 : 32'h0) | (32'(t) << 18) | (32'(s - l2[k]) << 8)
        | 32'(l2[k]), rd);
      ahb(1'b1, OFF_CLASS, 32'(cls[k]), rd);
      r = lfsr(r);
      n = 62 + 4 * int'(r[2:0]) + ((t == L4T_SCTP) ? 0 : int'(r[3]));
      for (int i = 0; i < n; i++) begin
        r = lfsr(r);
        p[i] = r[15:8];
      end
      if (t == L4T_SCTP) for (int i = 8; i < 12; i++) p[s + i] = 8'h00;
      c = (t == L4T_SCTP) ? crc(s, n) : {16'h0, l4sum(s, n)};
      if (t == L4T_UDP && c == 32'h0) c = 32'hFFFF;
      for (int i = 0; i < n; i++) u_host.pkt[i] = p[i];
      el = l2[k] >= 12 && cls[k][2:0] == 3'h0;
      ipe = v4 && l2[k] >= 12 && cls[k][4:3] != TUN_IPV6 && !(cls[k][4:3] == TUN_IPV4 && el);
      {p[l2[k] + 10], p[l2[k] + 11]} = 16'h0;
      ic = l4sum(l2[k], s);
      {p[l2[k] + 10], p[l2[k] + 11]} = ipe ? ic : {u_host.pkt[l2[k] + 10], u_host.pkt[l2[k] + 11]};
      if (el && t == L4T_SCTP) for (int i = 0; i < 4; i++) p[s + 8 + i] = c[8 * i +: 8];
      else if (el) {p[s + 6 + 10 * int'(t)], p[s + 7 + 10 * int'(t)]} = c[15:0];
      for (int i = 0; i < n; i++) exp_q.push_back('{data: p[i], last: i == n - 1});
      u_host.send(n, '{1'b1, 1'b1, 1'b1, t == L4T_SCTP});
      while (exp_q.size() != 0) @(posedge hclk);
      repeat (3) @(posedge hclk);
      ahb(1'b0, OFF_STATUS, 32'h0, rd);
      check(32'(rd[2]), 32'(el));
      check(32'(rd[1]), 32'(ipe));
      check(32'(rd[4]), 32'(l2[k] < 12));
      if (el) check(32'(rd[31:16]), c & 32'hFFFF);
      check(32'(rd[3]), 32'(t == L4T_SCTP));
      ahb(1'b1, OFF_STATUS, 32'h8, rd);
    end
    ahb(1'b0, OFF_COUNT, 32'h0, rd);
    check(rd, 32'h8);
    ahb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    give_verdict();
  end
endmodule // tco_tx_csum_offload_tb_top
